// ### inc/iect_regs.svh
// Register map, field positions, trap numbers and timing counts of the interrupt and event transfer controller
`ifndef IECT_REGS_SVH
`define IECT_REGS_SVH
// Sizes
`define IECT_NSRC          32
`define IECT_NCH           8
// Trap numbers and hardware trap level
`define IECT_SRC_TRAP_BASE 7'h10
`define IECT_NMI_TRAP      7'h02
`define IECT_OVF_TRAP      7'h04
`define IECT_UNF_TRAP      7'h06
`define IECT_CLASSB_TRAP   7'h0a
`define IECT_HW_LEVEL      4'hf
// Register word indices
`define IECT_A_TRAP_FLAGS  8'h40
`define IECT_A_OVF_LIM     8'h41
`define IECT_A_UNF_LIM     8'h42
`define IECT_A_STATUS      8'h43
// Address groups: sources 00..1f, channels 20..3f (channel in [4:2], slot in [1:0])
`define IECT_G_SRC         3'h0
`define IECT_G_CH          3'h1
`define IECT_SL_SRC        2'h0
`define IECT_SL_DST        2'h1
`define IECT_SL_CNT        2'h2
`define IECT_SL_CFG        2'h3
// Source control fields
`define IECT_SC_LVL_LSB    0
`define IECT_SC_CH_LSB     4
`define IECT_SC_DM         7
`define IECT_SC_EN         8
`define IECT_SC_REQ        9
// Channel config fields
`define IECT_CF_WORD       0
`define IECT_CF_INCDST     1
`define IECT_CF_CONT       2
// Trap flag bits
`define IECT_TF_NMI        15
`define IECT_TF_STKOF      14
`define IECT_TF_STKUF      13
`define IECT_TF_UNDOPC     7
`define IECT_TF_PRTFLT     3
`define IECT_TF_ILLOPA     2
`define IECT_TF_ILLINA     1
`define IECT_TF_ILLBUS     0
// Reset values
`define IECT_OVF_LIM_RST   16'h0000
`define IECT_UNF_LIM_RST   16'hffff
// Timing
`define IECT_CLK_PS        4000
`define IECT_LAT_MIN_NS    250
`define IECT_LAT_MAX_NS    600
`define IECT_LAT_MIN_CYC   ((`IECT_LAT_MIN_NS * 1000 + `IECT_CLK_PS - 1) / `IECT_CLK_PS)
`define IECT_LAT_MAX_CYC   ((`IECT_LAT_MAX_NS * 1000) / `IECT_CLK_PS)
`endif

// ### inc/iect_pkg.sv
// Types shared by the interrupt and event transfer controller
package iect_pkg;
  // Kind of vector offered to the core
  typedef enum logic [1:0] {VK_IRQ = 2'h0, VK_SWT = 2'h1, VK_HWA = 2'h2, VK_HWB = 2'h3} iect_kind_e;
  // Hardware trap service in progress, one-hot
  typedef enum logic [2:0] {TC_NONE = 3'h1, TC_B = 3'h2, TC_A = 3'h4} iect_tcls_e;
  // Vector offered to the core
  typedef struct packed {
    logic [8:0] addr;
    logic [6:0] num;
    logic [3:0] level;
    iect_kind_e kind;
  } iect_vec_s;
  // One stolen data-move cycle
  typedef struct packed {
    logic [15:0] src;
    logic [15:0] dst;
    logic        word;
    logic [2:0]  chan;
  } iect_dm_s;
endpackage

// ### src/iect_ctrl.sv
// Interrupt arbiter, event data mover and hardware trap logic
//
// Functional notes
// - Each source picks vector or data-move service
// - Data move steals exactly one cycle
// - Move byte/word, bump source or destination pointer
// - Counter decrements unless continuous mode
// - Counter zero gives standard interrupt instead
// - Eight channels with pointers and counter
// - Per-source register: request, enable, priority
// - Sixteen priority levels arbitrate pending requests
// - Only strictly higher priority preempts service
// - Source traps 10h-2Fh, vector four times number
// - Fixed source order by trap number
// - Software trap instruction selects vector number
// - Hardware traps non-maskable, branch to vector
// - Each hardware trap sets its flag bit
// - Trap interrupts unless same or higher class running
// - Trap service blocks interrupts and data moves
// - Interrupt latency between 250 and 600 ns
// - Stack pointer checked against both limits
// - Class A vectors: NMI, overflow, underflow
// - Class B traps share one vector
// - Software trap 00h-7Fh at current priority
//
// Implementation choices: strobed register access and the address map.
`timescale 1ns/1ps
`include "iect_regs.svh"
`default_nettype none

module iect_ctrl
  import iect_pkg::*;
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rstn,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output var  logic [15:0] reg_rdata,
  // Peripheral request pulses, one per source
  input  wire logic [31:0] periph_req,
  // Core side
  input  wire logic [3:0]  cpu_level,
  input  wire logic        vec_ack,
  input  wire logic        trap_exit,
  input  wire logic        sw_trap,
  input  wire logic [6:0]  sw_trap_num,
  input  wire logic        stack_access,
  input  wire logic [15:0] stack_pointer,
  input  wire logic [4:0]  class_b_evt,
  // Non-maskable request pin, active low
  input  wire logic        nmi_n,
  // Vector offer
  output var  logic        vec_req,
  output var  iect_vec_s   vec,
  // Data-move cycle
  output var  logic        dm_go,
  output var  iect_dm_s    dm
);

  localparam int LATMIN = `IECT_LAT_MIN_CYC;   // Least response, in cycles
  localparam int LATMAX = `IECT_LAT_MAX_CYC;   // Longest response, in cycles

  // Source control fields
  logic [3:0]  src_lvl [`IECT_NSRC];           // Priority level per source
  logic [2:0]  src_ch  [`IECT_NSRC];           // Data-move channel per source
  logic [31:0] src_dm;                         // Serviced by data mover
  logic [31:0] src_en;                         // Enable flags
  logic [31:0] src_req;                        // Request flags
  // Data-move channels
  logic [15:0] ch_src [`IECT_NCH];             // Source pointers
  logic [15:0] ch_dst [`IECT_NCH];             // Destination pointers
  logic [15:0] ch_cnt [`IECT_NCH];             // Transfer counters
  logic [2:0]  ch_cfg [`IECT_NCH];             // Word, increment target, continuous
  // Traps
  logic [15:0] trap_flag_reg;                  // Sticky trap flags
  logic [15:0] stack_overflow_limit;           // Lowest legal stack pointer
  logic [15:0] stack_underflow_limit;          // Highest legal stack pointer
  logic        pend_nmi, pend_ov, pend_un, pend_b;
  logic        pend_sw;                        // Software trap waiting
  logic [6:0]  sw_num;                         // Its trap number
  iect_tcls_e  trap_cls;                       // Trap service running
  logic [4:0]  vec_src;                        // Source behind offered vector
  logic [7:0]  lat_cnt;                        // Cycles a vectored candidate waited
  // Pin synchroniser
  logic        nmi_s1, nmi_s2, nmi_s3, nmi_lvl;
  logic        nmi_fall;

  // Arbitration results
  logic        best_ok;
  logic [4:0]  best_idx;
  logic [3:0]  best_lvl;
  logic [2:0]  best_ch;
  logic        arb_open, dm_ok, dm_fire, irq_cand, irq_fire;
  logic        vec_hw, hw_a, hw_sel_a, hw_go, acked;
  logic [6:0]  hw_num;
  logic [15:0] tf_set;
  logic        g_src, g_ch;

  assign g_src  = reg_addr[7:5] == `IECT_G_SRC;
  assign g_ch   = reg_addr[7:5] == `IECT_G_CH;
  assign vec_hw = (vec.kind == VK_HWA) || (vec.kind == VK_HWB);
  assign acked  = vec_ack && vec_req;

  // Highest enabled level above the running level wins; ties keep the lowest trap number
  always_comb begin
    best_ok  = 1'b0;
    best_idx = 5'h00;
    best_lvl = 4'h0;
    for (int i = 0; i < `IECT_NSRC; i++) begin
      if (src_req[i] && src_en[i] && (src_lvl[i] > cpu_level) &&
          (!best_ok || (src_lvl[i] > best_lvl))) begin
        best_ok  = 1'b1;
        best_idx = 5'(i);
        best_lvl = src_lvl[i];
      end
    end
  end

  // Route the winner to the mover or to a vector; the trap service shuts both out
  always_comb begin
    best_ch  = src_ch[best_idx];
    arb_open = !vec_req && (trap_cls == TC_NONE);
    dm_ok    = src_dm[best_idx] &&
               ((ch_cnt[best_ch] != 16'h0000) || ch_cfg[best_ch][`IECT_CF_CONT]);
    dm_fire  = arb_open && best_ok && dm_ok;
    irq_cand = arb_open && best_ok && !dm_ok;
    irq_fire = irq_cand && !pend_sw && (lat_cnt == 8'(LATMIN - 1));
  end

  // Hardware trap choice: class A beats class B, and NMI beats the stack checks
  always_comb begin
    hw_a     = pend_nmi || pend_ov || pend_un;
    hw_sel_a = hw_a && (trap_cls != TC_A);
    hw_go    = (hw_sel_a || (pend_b && (trap_cls == TC_NONE))) && !(vec_req && vec_hw);
    if (!hw_sel_a) begin
      hw_num = `IECT_CLASSB_TRAP;
    end else if (pend_nmi) begin
      hw_num = `IECT_NMI_TRAP;
    end else if (pend_ov) begin
      hw_num = `IECT_OVF_TRAP;
    end else begin
      hw_num = `IECT_UNF_TRAP;
    end
  end

  // Trap events that set sticky flags
  always_comb begin
    tf_set                   = 16'h0000;
    tf_set[`IECT_TF_NMI]     = nmi_fall;
    tf_set[`IECT_TF_STKOF]   = stack_access && (stack_pointer < stack_overflow_limit);
    tf_set[`IECT_TF_STKUF]   = stack_access && (stack_pointer > stack_underflow_limit);
    tf_set[`IECT_TF_ILLBUS]  = class_b_evt[0];
    tf_set[`IECT_TF_ILLINA]  = class_b_evt[1];
    tf_set[`IECT_TF_ILLOPA]  = class_b_evt[2];
    tf_set[`IECT_TF_PRTFLT]  = class_b_evt[3];
    tf_set[`IECT_TF_UNDOPC]  = class_b_evt[4];
  end

  // Three-stage pin synchroniser; only agreeing later stages move the filtered level
  always_ff @(posedge clock) begin
    if (!rstn) begin
      nmi_s1  <= 1'b1;
      nmi_s2  <= 1'b1;
      nmi_s3  <= 1'b1;
      nmi_lvl <= 1'b1;
    end else begin
      nmi_s1 <= nmi_n;
      nmi_s2 <= nmi_s1;
      nmi_s3 <= nmi_s2;
      if (nmi_s2 == nmi_s3) begin
        nmi_lvl <= nmi_s3;
      end
    end
  end
  // High to low on the filtered level is the request
  assign nmi_fall = (nmi_s2 == nmi_s3) && !nmi_s3 && nmi_lvl;

  // Per-source control registers; a peripheral pulse wins over any clear
  for (genvar i = 0; i < `IECT_NSRC; i++) begin : g_src_reg
    logic wr_i;
    logic clr_i;
    assign wr_i  = reg_wr && g_src && (reg_addr[4:0] == 5'(i));
    assign clr_i = (dm_fire && (best_idx == 5'(i))) ||
                   (acked && (vec.kind == VK_IRQ) && (vec_src == 5'(i)));
    always_ff @(posedge clock) begin
      if (!rstn) begin
        src_lvl[i] <= 4'h0;
        src_ch[i]  <= 3'h0;
        src_dm[i]  <= 1'b0;
        src_en[i]  <= 1'b0;
        src_req[i] <= 1'b0;
      end else begin
        if (wr_i) begin
          src_lvl[i] <= reg_wdata[`IECT_SC_LVL_LSB +: 4];
          src_ch[i]  <= reg_wdata[`IECT_SC_CH_LSB +: 3];
          src_dm[i]  <= reg_wdata[`IECT_SC_DM];
          src_en[i]  <= reg_wdata[`IECT_SC_EN];
        end
        src_req[i] <= periph_req[i] | (wr_i ? reg_wdata[`IECT_SC_REQ] : (src_req[i] & !clr_i));
      end
    end
  end

  // Per-channel registers; a move in progress takes the channel over software
  for (genvar c = 0; c < `IECT_NCH; c++) begin : g_ch_reg
    logic        hit_c, wr_c;
    logic [15:0] step_c;
    assign hit_c  = dm_fire && (best_ch == 3'(c));
    assign wr_c   = reg_wr && g_ch && (reg_addr[4:2] == 3'(c));
    assign step_c = ch_cfg[c][`IECT_CF_WORD] ? 16'h0002 : 16'h0001;
    always_ff @(posedge clock) begin
      if (!rstn) begin
        ch_src[c] <= 16'h0000;
        ch_dst[c] <= 16'h0000;
        ch_cnt[c] <= 16'h0000;
        ch_cfg[c] <= 3'h0;
      end else if (hit_c) begin
        if (ch_cfg[c][`IECT_CF_INCDST]) begin
          ch_dst[c] <= ch_dst[c] + step_c;
        end else begin
          ch_src[c] <= ch_src[c] + step_c;
        end
        if (!ch_cfg[c][`IECT_CF_CONT]) begin
          ch_cnt[c] <= ch_cnt[c] - 16'h0001;
        end
      end else if (wr_c) begin
        unique case (reg_addr[1:0])
          `IECT_SL_SRC: ch_src[c] <= reg_wdata;
          `IECT_SL_DST: ch_dst[c] <= reg_wdata;
          `IECT_SL_CNT: ch_cnt[c] <= reg_wdata;
          `IECT_SL_CFG: ch_cfg[c] <= reg_wdata[2:0];
        endcase
      end
    end
  end

  // One stolen cycle per move: a pulse with the addresses, no vector involved
  always_ff @(posedge clock) begin
    if (!rstn) begin
      dm_go <= 1'b0;
      dm    <= '0;
    end else begin
      dm_go <= dm_fire;
      if (dm_fire) begin
        dm.src  <= ch_src[best_ch];
        dm.dst  <= ch_dst[best_ch];
        dm.word <= ch_cfg[best_ch][`IECT_CF_WORD];
        dm.chan <= best_ch;
      end
    end
  end

  // Latency counter: the vector waits out the least response time
  always_ff @(posedge clock) begin
    if (!rstn || !irq_cand || irq_fire) begin
      lat_cnt <= 8'h00;
    end else if (lat_cnt != 8'(LATMIN - 1)) begin
      lat_cnt <= lat_cnt + 8'h01;
    end
  end

  // Trap flags, limits and pending hardware traps; events win over clears
  always_ff @(posedge clock) begin
    if (!rstn) begin
      trap_flag_reg         <= 16'h0000;
      stack_overflow_limit  <= `IECT_OVF_LIM_RST;
      stack_underflow_limit <= `IECT_UNF_LIM_RST;
      pend_nmi              <= 1'b0;
      pend_ov               <= 1'b0;
      pend_un               <= 1'b0;
      pend_b                <= 1'b0;
    end else begin
      trap_flag_reg <= tf_set | ((reg_wr && reg_addr == `IECT_A_TRAP_FLAGS) ? reg_wdata : trap_flag_reg);
      if (reg_wr && reg_addr == `IECT_A_OVF_LIM) begin
        stack_overflow_limit <= reg_wdata;
      end
      if (reg_wr && reg_addr == `IECT_A_UNF_LIM) begin
        stack_underflow_limit <= reg_wdata;
      end
      pend_nmi <= nmi_fall | (pend_nmi & !(acked && vec_hw && vec.num == `IECT_NMI_TRAP));
      pend_ov  <= tf_set[`IECT_TF_STKOF] | (pend_ov & !(acked && vec_hw && vec.num == `IECT_OVF_TRAP));
      pend_un  <= tf_set[`IECT_TF_STKUF] | (pend_un & !(acked && vec_hw && vec.num == `IECT_UNF_TRAP));
      pend_b   <= (|class_b_evt) | (pend_b & !(acked && vec.kind == VK_HWB));
    end
  end

  // Software trap capture; the core's own instruction, so no gating by traps
  always_ff @(posedge clock) begin
    if (!rstn) begin
      pend_sw <= 1'b0;
      sw_num  <= 7'h00;
    end else if (sw_trap) begin
      pend_sw <= 1'b1;
      sw_num  <= sw_trap_num;
    end else if (acked && vec.kind == VK_SWT) begin
      pend_sw <= 1'b0;
    end
  end

  // Trap service state: entered on acceptance, left when the core returns
  always_ff @(posedge clock) begin
    if (!rstn) begin
      trap_cls <= TC_NONE;
    end else if (acked && vec.kind == VK_HWA) begin
      trap_cls <= TC_A;
    end else if (acked && vec.kind == VK_HWB) begin
      trap_cls <= TC_B;
    end else if (trap_exit) begin
      trap_cls <= TC_NONE;
    end
  end

  // Vector offer; a hardware trap may replace an unaccepted lower offer
  always_ff @(posedge clock) begin
    if (!rstn) begin
      vec_req <= 1'b0;
      vec     <= '0;
      vec_src <= 5'h00;
    end else if (hw_go) begin
      vec_req    <= 1'b1;
      vec.num    <= hw_num;
      vec.addr   <= {hw_num, 2'h0};
      vec.level  <= `IECT_HW_LEVEL;
      vec.kind   <= hw_sel_a ? VK_HWA : VK_HWB;
    end else if (acked) begin
      vec_req <= 1'b0;
    end else if (pend_sw && !vec_req) begin
      vec_req    <= 1'b1;
      vec.num    <= sw_num;
      vec.addr   <= {sw_num, 2'h0};
      vec.level  <= cpu_level;
      vec.kind   <= VK_SWT;
    end else if (irq_fire) begin
      vec_req    <= 1'b1;
      vec.num    <= `IECT_SRC_TRAP_BASE + {2'h0, best_idx};
      vec.addr   <= {`IECT_SRC_TRAP_BASE + {2'h0, best_idx}, 2'h0};
      vec.level  <= best_lvl;
      vec.kind   <= VK_IRQ;
      vec_src    <= best_idx;
    end
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge clock) begin
    if (!rstn || !reg_rd) begin
      reg_rdata <= 16'h0000;
    end else if (g_src) begin
      reg_rdata <= {6'h00, src_req[reg_addr[4:0]], src_en[reg_addr[4:0]], src_dm[reg_addr[4:0]],
                    src_ch[reg_addr[4:0]], src_lvl[reg_addr[4:0]]};
    end else if (g_ch) begin
      unique case (reg_addr[1:0])
        `IECT_SL_SRC: reg_rdata <= ch_src[reg_addr[4:2]];
        `IECT_SL_DST: reg_rdata <= ch_dst[reg_addr[4:2]];
        `IECT_SL_CNT: reg_rdata <= ch_cnt[reg_addr[4:2]];
        `IECT_SL_CFG: reg_rdata <= {13'h0000, ch_cfg[reg_addr[4:2]]};
      endcase
    end else begin
      unique case (reg_addr)
        `IECT_A_TRAP_FLAGS: reg_rdata <= trap_flag_reg;
        `IECT_A_OVF_LIM: reg_rdata <= stack_overflow_limit;
        `IECT_A_UNF_LIM: reg_rdata <= stack_underflow_limit;
        `IECT_A_STATUS: reg_rdata <= {11'h000, pend_sw, trap_cls == TC_A, trap_cls == TC_B, dm_go, vec_req};
        default:        reg_rdata <= 16'h0000;                           // Unmapped reads zero
      endcase
    end
  end

  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  chk_lat_min: assert property ($rose(vec_req) && vec.kind == VK_IRQ |->
      $past(lat_cnt) == 8'(LATMIN - 1)) else $error("interrupt offered before least latency");
  chk_lat_max: assert property (irq_cand && !pend_sw && lat_cnt == 8'(LATMIN - 1) |=>
      vec_req && lat_cnt < 8'(LATMAX)) else $error("interrupt latency over longest bound");
  chk_cnt_dec: assert property (dm_fire && !ch_cfg[best_ch][`IECT_CF_CONT] |=>
      ch_cnt[dm.chan] == $past(ch_cnt[best_ch]) - 16'h0001) else $error("transfer counter not decremented");
  chk_cnt_hold: assert property (dm_fire && ch_cfg[best_ch][`IECT_CF_CONT] |=>
      ch_cnt[dm.chan] == $past(ch_cnt[best_ch])) else $error("continuous counter changed");
  chk_ptr_step: assert property (dm_fire && !ch_cfg[best_ch][`IECT_CF_INCDST] && !ch_cfg[best_ch][`IECT_CF_WORD]
      |=> ch_src[dm.chan] == dm.src + 16'h0001) else $error("source pointer not stepped");
  chk_flag_clear: assert property (acked && vec.kind == VK_IRQ && !periph_req[vec_src] && !reg_wr
      |=> !src_req[$past(vec_src)]) else $error("request flag kept after acceptance");
  chk_vec_range: assert property (vec_req && vec.kind == VK_IRQ |->
      vec.num >= 7'h10 && vec.num <= 7'h2f && vec.addr == {vec.num, 2'h0}) else $error("bad source vector");
  chk_preempt_lvl: assert property ($rose(vec_req) && vec.kind == VK_IRQ |->
      vec.level > $past(cpu_level, 2)) else $error("interrupt not above running level");
  chk_trap_block: assert property ($past(trap_cls) != TC_NONE |-> !dm_go)
      else $error("data move during trap service");
  chk_tfr_nmi: assert property (nmi_fall |=> trap_flag_reg[`IECT_TF_NMI])
      else $error("trap flag missing");
  chk_nmi_vec: assert property (nmi_fall && trap_cls != TC_A && !(vec_req && vec_hw) && !vec_ack
      |-> ##2 vec_req && vec.num == `IECT_NMI_TRAP) else $error("NMI vector not offered");

  cov_dm_move:   cover property (dm_go);
  cov_irq_vec:   cover property ($rose(vec_req) && vec.kind == VK_IRQ);
  cov_nmi_trap:  cover property (acked && vec.kind == VK_HWA);
  cov_sw_trap:   cover property (acked && vec.kind == VK_SWT);

endmodule
`default_nettype wire

// ### tb/iect_core_model.sv
// Core model: takes offered vectors and leaves trap routines
`timescale 1ns/1ps
`default_nettype none
module iect_core_model
  import iect_pkg::*;
#(
  parameter int EXIT_DLY = 100  // Cycles spent inside a trap routine
) (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       rstn,
  // Offer from the controller
  input  wire logic       vec_req,
  input  wire iect_vec_s  vec,
  input  wire logic [7:0] ack_dly,
  // Answers to the controller
  output var  logic       vec_ack,
  output var  logic       trap_exit
);
  int wait_cnt;  // Cycles the offer has waited
  int exit_cnt;  // Cycles left in a trap routine
  // Ack lasts one cycle, so a held offer is never taken twice
  always_ff @(posedge clock) begin
    if (!rstn) begin
      vec_ack   <= 1'b0;
      trap_exit <= 1'b0;
      wait_cnt  <= 0;
      exit_cnt  <= 0;
    end else begin
      vec_ack   <= 1'b0;
      trap_exit <= (exit_cnt == 1);
      exit_cnt  <= (exit_cnt > 0) ? exit_cnt - 1 : 0;
      wait_cnt  <= 0;
      // Slow or prompt acceptance as the bench asks
      if (vec_req && !vec_ack) begin
        wait_cnt <= wait_cnt + 1;
        if (wait_cnt >= int'(ack_dly)) begin
          vec_ack <= 1'b1;
          // Hardware trap routines end with an exit pulse
          if (vec.kind[1]) exit_cnt <= EXIT_DLY;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ### tb/iect_ctrl_tb_top.sv
// Self-checking bench for the interrupt and event transfer controller
`timescale 1ns/1ps
`default_nettype none
module iect_ctrl_tb_top;
  import iect_pkg::*;
  // Design inputs
  logic        clock = 1'b0;
  logic        rstn = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [31:0] periph_req = 32'h0;
  logic [3:0]  cpu_level = 4'h0;
  logic        sw_trap = 1'b0;
  logic [6:0]  sw_trap_num = 7'h00;
  logic        stack_access = 1'b0;
  logic [15:0] stack_pointer = 16'h0200;
  logic [4:0]  class_b_evt = 5'h00;
  logic        nmi_n = 1'b1;
  logic [7:0]  ack_dly = 8'h02;
  // Design outputs and model answers
  logic [15:0] reg_rdata;
  logic        vec_ack;
  logic        trap_exit;
  logic        vec_req;
  logic        dm_go;
  iect_vec_s   vec;
  iect_dm_s    dm;
  // Bench state and tables
  int          error_cnt = 0;
  int          checks = 0;
  int          seed = 42;
  int          n;
  int          k;
  logic [15:0] rd;
  logic [6:0]  t;
  logic [3:0]  lv;
  logic [7:0]  ra[4] = '{8'h40, 8'h41, 8'h42, 8'h7f};
  logic [15:0] rv[4] = '{16'h0, 16'h0, 16'hffff, 16'h0};
  logic [15:0] sps[3] = '{16'h0080, 16'h0f10, 16'h0800};
  logic [15:0] sfl[3] = '{16'h4000, 16'h2000, 16'h0000};
  int          tfb[5] = '{0, 1, 2, 3, 7};

  always #2 clock = ~clock;

  iect_ctrl i_iect_ctrl (
    .clock(clock), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .periph_req(periph_req), .cpu_level(cpu_level),
    .vec_ack(vec_ack), .trap_exit(trap_exit), .sw_trap(sw_trap), .sw_trap_num(sw_trap_num),
    .stack_access(stack_access), .stack_pointer(stack_pointer), .class_b_evt(class_b_evt),
    .nmi_n(nmi_n), .vec_req(vec_req), .vec(vec), .dm_go(dm_go), .dm(dm));
  iect_core_model i_iect_core_model (
    .clock(clock), .rstn(rstn), .vec_req(vec_req), .vec(vec), .ack_dly(ack_dly),
    .vec_ack(vec_ack), .trap_exit(trap_exit));

  // Compare and count
  task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Verdict and end of run
  task automatic report_and_stop();
    if (error_cnt == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Register write, one strobe cycle
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  // Register read, data taken in the following cycle only
  task automatic rdr(input logic [7:0] a);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 rd = reg_rdata;
  endtask
  // One-cycle peripheral request
  task automatic pulse(input logic [31:0] m);
    @(posedge clock);
    periph_req <= m;
    @(posedge clock);
    periph_req <= 32'h0;
    #1;
  endtask
  // Bounded wait for an offer; n counts edges since the request edge
  task automatic wait_vec(input int lim);
    n = 1;
    while (vec_req !== 1'b1 && n < lim) begin
      @(posedge clock);
      #1 n++;
    end
  endtask
  // Expected vector: address is four times the number
  function automatic iect_vec_s ev(input logic [6:0] num, input logic [3:0] l, input iect_kind_e kd);
    return '{addr: {num, 2'b00}, num: num, level: l, kind: kd};
  endfunction
  // Set a channel up, fire its source, check the stolen cycle and the updates
  task automatic move(input int s, input logic [2:0] ch, input logic [2:0] cfg, input logic [15:0] cnt);
    logic [7:0] b;
    b = 8'h20 + {3'h0, ch, 2'h0};
    wr(b, 16'h1000);
    wr(b + 8'h1, 16'h2000);
    wr(b + 8'h2, cnt);
    wr(b + 8'h3, {13'h0, cfg});
    wr(8'(s), {7'h00, 2'b11, ch, 4'h3});
    pulse(32'h1 << s);
    @(posedge clock);
    #1 chk(dm_go, 1'b1);
    chk(dm, {16'h1000, 16'h2000, cfg[0], ch});
    @(posedge clock);
    #1 chk(dm_go, 1'b0);
    rdr(b + {7'h0, cfg[1]});
    chk(rd, (cfg[1] ? 16'h2000 : 16'h1000) + (cfg[0] ? 16'h2 : 16'h1));
    rdr(b + 8'h2);
    chk(rd, cfg[2] ? cnt : cnt - 16'h1);
  endtask

  // Run ends here if the sequence hangs; normal run is far shorter
  initial begin
    #100000;
    error_cnt++;
    report_and_stop();
  end

  initial begin
    repeat (12) @(posedge clock);
    rstn <= 1'b1;
    // Reset values, then an unmapped word
    for (int i = 0; i < 4; i++) begin
      rdr(ra[i]);
      chk(rd, rv[i]);
    end
    // Word move on source, byte continuous move on destination, random channel
    move(5, 3'h2, 3'h1, 16'h0002);
    move(6, 3'h3, 3'h6, 16'h0000);
    move(8 + {$random(seed)} % 24, 3'($random(seed)), 3'($random(seed)), 16'h0005);
    // Count runs out: next request becomes a vector
    move(12, 3'h5, 3'h0, 16'h0001);
    pulse(32'h1 << 12);
    @(posedge clock);
    #1 chk(dm_go, 1'b0);
    wait_vec(200);
    chk(vec, ev(7'h1c, 4'h3, VK_IRQ));
    repeat (12) @(posedge clock);
    // Random vectored sources, latency and flag clearing
    for (int i = 0; i < 4; i++) begin
      k = {$random(seed)} % 32;
      lv = 4'h1 + 4'({$random(seed)} % 15);
      ack_dly <= 8'({$random(seed)} % 8);
      wr(8'(k), {7'h00, 2'b10, 3'h0, lv});
      pulse(32'h1 << k);
      wait_vec(200);
      chk(n, 64);
      chk(vec, ev(7'h10 + 7'(k), lv, VK_IRQ));
      repeat (12) @(posedge clock);
      rdr(8'(k));
      chk(rd[9], 1'b0);
    end
    // Equal levels go to the lower number; a higher level wins over it
    for (int i = 0; i < 2; i++) begin
      wr(8'h09, {12'h010, 4'h4 + 4'(2 * i)});
      wr(8'h04, 16'h0104);
      pulse(32'h0000_0210);
      wait_vec(200);
      chk(vec.num, i ? 7'h19 : 7'h14);
      repeat (12) @(posedge clock);
      wait_vec(200);
      chk(vec.num, i ? 7'h14 : 7'h19);
      repeat (12) @(posedge clock);
    end
    // Equal to the running level waits; one level higher gets through
    cpu_level <= 4'h5;
    wr(8'h07, 16'h0105);
    pulse(32'h1 << 7);
    wait_vec(100);
    chk(vec_req, 1'b0);
    wr(8'h07, 16'h0306);
    wait_vec(200);
    chk(vec, ev(7'h17, 4'h6, VK_IRQ));
    repeat (12) @(posedge clock);
    cpu_level <= 4'h0;
    // Class B trap, its flag, and interrupts held off during the routine
    k = {$random(seed)} % 5;
    @(posedge clock);
    class_b_evt <= 5'h1 << k;
    @(posedge clock);
    class_b_evt <= 5'h00;
    #1 wait_vec(20);
    chk(vec, ev(7'h0a, 4'hf, VK_HWB));
    rdr(8'h40);
    chk(rd, 16'h1 << tfb[k]);
    wr(8'h01, 16'h010f);
    pulse(32'h2);
    wait_vec(80);
    chk(vec_req, 1'b0);
    rdr(8'h43);
    chk(rd, 16'h0004);
    wait_vec(200);
    chk(vec.num, 7'h11);
    repeat (12) @(posedge clock);
    // Falling pin edge raises the non-maskable trap
    wr(8'h40, 16'h0000);
    @(posedge clock);
    nmi_n <= 1'b0;
    #1 wait_vec(20);
    chk(vec, ev(7'h02, 4'hf, VK_HWA));
    rdr(8'h40);
    chk(rd, 16'h8000);
    @(posedge clock);
    nmi_n <= 1'b1;
    repeat (110) @(posedge clock);
    // Stack pointer below, above, then inside the limits
    wr(8'h41, 16'h0100);
    wr(8'h42, 16'h0f00);
    for (int i = 0; i < 3; i++) begin
      wr(8'h40, 16'h0000);
      @(posedge clock);
      stack_access <= 1'b1;
      stack_pointer <= sps[i];
      @(posedge clock);
      stack_access <= 1'b0;
      #1 wait_vec(20);
      chk(vec_req, i < 2);
      if (i < 2) chk(vec, ev(7'h04 + 7'(2 * i), 4'hf, VK_HWA));
      rdr(8'h40);
      chk(rd, sfl[i]);
      repeat (110) @(posedge clock);
    end
    // Software traps at both ends of the range and one random
    for (int i = 0; i < 3; i++) begin
      t = (i == 0) ? 7'h7f : (i == 1) ? 7'h00 : 7'($random(seed));
      cpu_level <= 4'($random(seed));
      @(posedge clock);
      sw_trap <= 1'b1;
      sw_trap_num <= t;
      @(posedge clock);
      sw_trap <= 1'b0;
      #1 wait_vec(100);
      chk(vec, ev(t, cpu_level, VK_SWT));
      repeat (12) @(posedge clock);
    end
    report_and_stop();
  end
endmodule
`default_nettype wire
